// ==== include/device_config_pkg.sv ====
// Constants, types and field layout of the device configuration register.
// Functional notes
// - Software reset bit written 0 acts as pin reset, straps not resampled.
// - While reset bit is 0, transmission halts and other bits hold default.
// - Rate field 01 gives 10.24 MHz, 10 gives 15.36 MHz, 11 tri-states.
// - Auto maintenance enable 1 ignores host maintenance bits; state machine inserts.
// - Auto maintenance enable 0 makes maintenance bits follow host register values.
// - Auto overhead enable 1 runs state machine, ignores its control registers.
// - Overhead state machine accepts only addresses 000 and 111.
// - Multiframing select 0 enables controller and S/Q access; 1 disables it.
// - Multiframing disabled sends zeros in FA and M, ones in S.
// - Multiframing disabled reads Q bits as ones, S subchannel bits zeros.
// - Trigger 1-to-0 starts one activation attempt, then bit returns to 1.
// - Strap low at reset release loads trigger 0 and starts one attempt.
// - Register reached through synchronous serial microprocessor port.
package device_config_pkg;

  localparam logic [6:0] device_configuration_addr = 7'h00;
  localparam int addr_width = 7;
  localparam int data_width = 8;
  localparam int frame_bits = 1 + addr_width + data_width;

  localparam int bit_soft_reset_n = 0;
  localparam int bit_rate_lo = 1;
  localparam int bit_rate_hi = 2;
  localparam int bit_auto_maint = 3;
  localparam int bit_auto_overhead = 4;
  localparam int bit_multiframing = 5;
  localparam int bit_activation = 6;
  localparam int bit_reserved = 7;

  localparam logic [7:0] config_reset_value = 8'hff;
  localparam logic [3:0] q_forced_value = 4'hf;
  localparam logic [3:0] s_forced_value = 4'h0;
  localparam logic [2:0] eoc_addr_valid_a = 3'h0;
  localparam logic [2:0] eoc_addr_valid_b = 3'h7;
  localparam int maint_width = 6;
  localparam int s_subchannels = 5;

  typedef enum logic [1:0] {
    rate_unused = 2'h0,
    rate_10m24_locked = 2'h1,
    rate_15m36_free = 2'h2,
    rate_tristate = 2'h3
  } clock_rate_t;

  typedef struct packed {
    logic activation_trigger;
    logic multiframing_select;
    logic auto_overhead_channel_enable;
    logic auto_maintenance_enable;
    clock_rate_t clock_out_rate_select;
    logic soft_reset_n;
  } dev_cfg_t;

  typedef struct packed {
    logic fa_m_force_zero;
    logic s_force_one;
    logic mf_controller_enable;
  } frame_ctl_t;

endpackage : device_config_pkg

// ==== rtl/device_config_control.sv ====
// Device configuration register with its serial host port and control decodes.
`timescale 1ns/100ps
`default_nettype none
module device_config_control #(
  parameter int maint_bits = device_config_pkg::maint_width,
  parameter int subchannels = device_config_pkg::s_subchannels
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic host_sclk,
  input wire logic host_cs_n,
  input wire logic host_sdi,
  output logic host_sdo,
  output logic host_sdo_oe_n,
  input wire logic activation_strap_pin,
  input wire logic u_interface_active,
  input wire logic activation_done,
  input wire logic [maint_bits-1:0] maint_auto_bits,
  input wire logic [maint_bits-1:0] maintenance_control_register,
  input wire logic [2:0] eoc_rx_addr,
  input wire logic [3:0] q_channel_raw,
  input wire logic [subchannels*4-1:0] s_subchannel_raw,
  output device_config_pkg::dev_cfg_t cfg,
  output logic device_reset_n,
  output logic aux_clock_oe_n,
  output logic aux_clock_locked,
  output logic aux_clock_fast,
  output logic [maint_bits-1:0] maint_bits_out,
  output logic eoc_sm_enable,
  output logic eoc_manual_enable,
  output logic eoc_addr_accept,
  output device_config_pkg::frame_ctl_t frame_ctl,
  output logic [3:0] q_channel_register,
  output logic [subchannels*4-1:0] s_subchannel_registers,
  output logic activation_attempt
);

  function automatic logic eoc_addr_ok(input logic [2:0] a);
    eoc_addr_ok = (a == device_config_pkg::eoc_addr_valid_a) ||
                  (a == device_config_pkg::eoc_addr_valid_b);
  endfunction : eoc_addr_ok

  function automatic logic [7:0] cfg_to_byte(input device_config_pkg::dev_cfg_t c);
    cfg_to_byte = {1'b1, c};
  endfunction : cfg_to_byte

  // Two-stage synchronisers for the pins.
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 4'h5;
      sync2_q <= 4'h5;
    end else begin
      sync1_q <= {host_sclk, host_cs_n, host_sdi, activation_strap_pin};
      sync2_q <= sync1_q;
    end
  end

  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic strap_s;
  assign sclk_s = sync2_q[3];
  assign cs_n_s = sync2_q[2];
  assign sdi_s = sync2_q[1];
  assign strap_s = sync2_q[0];

  logic sclk_prev_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;

  // Serial frame: read flag, seven address bits, eight data bits, MSB first.
  localparam int frame_bits_l = device_config_pkg::frame_bits;
  logic [4:0] bit_cnt_q;
  logic [frame_bits_l-1:0] shift_in_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_q <= 5'h00;
      shift_in_q <= '0;
    end else if (cs_n_s) begin
      bit_cnt_q <= 5'h00;
    end else if (sclk_rise) begin
      shift_in_q <= {shift_in_q[frame_bits_l-2:0], sdi_s};
      if (bit_cnt_q != 5'(frame_bits_l)) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  logic header_done;
  logic frame_done;
  logic is_read;
  logic addr_hit;
  assign header_done = sclk_rise && (bit_cnt_q == 5'h07);
  assign frame_done = sclk_rise && (bit_cnt_q == 5'(frame_bits_l - 1));
  assign is_read = shift_in_q[frame_bits_l-2];
  assign addr_hit = shift_in_q[frame_bits_l-3:7] == device_config_pkg::device_configuration_addr;

  logic wr_en;
  logic [7:0] wr_data;
  assign wr_en = frame_done && !is_read && addr_hit;
  assign wr_data = {shift_in_q[6:0], sdi_s};

  // Read path: the byte is captured after the header and shifted on falling edges.
  logic [7:0] shift_out_q;
  logic reading_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_out_q <= 8'h00;
      reading_q <= 1'b0;
      host_sdo <= 1'b0;
    end else if (cs_n_s) begin
      reading_q <= 1'b0;
    end else if (header_done) begin
      reading_q <= shift_in_q[6];
      // Unmapped addresses read as zero.
      shift_out_q <= ({shift_in_q[5:0], sdi_s} == device_config_pkg::device_configuration_addr) ?
                     cfg_to_byte(cfg) : 8'h00;
    end else if (sclk_fall && reading_q) begin
      host_sdo <= shift_out_q[7];
      shift_out_q <= {shift_out_q[6:0], 1'b0};
    end
  end
  assign host_sdo_oe_n = ~reading_q;

  // Strap capture one cycle after the synchroniser settles past reset release.
  logic [1:0] boot_cnt_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_cnt_q <= 2'h0;
    end else if (boot_cnt_q != 2'h3) begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
    end
  end
  logic strap_load;
  assign strap_load = (boot_cnt_q == 2'h2);

  // Configuration register.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= device_config_pkg::config_reset_value[6:0];
    end else if (strap_load && !strap_s) begin
      cfg.activation_trigger <= 1'b0;
    end else if (wr_en && !wr_data[device_config_pkg::bit_soft_reset_n]) begin
      cfg <= device_config_pkg::config_reset_value[6:0];
      cfg.soft_reset_n <= 1'b0;
    end else if (!cfg.soft_reset_n) begin
      if (wr_en) begin
        cfg.soft_reset_n <= 1'b1;
      end
    end else begin
      if (wr_en) begin
        cfg.clock_out_rate_select <= device_config_pkg::clock_rate_t'(
          wr_data[device_config_pkg::bit_rate_hi:device_config_pkg::bit_rate_lo]);
        cfg.auto_maintenance_enable <= wr_data[device_config_pkg::bit_auto_maint];
        cfg.auto_overhead_channel_enable <= wr_data[device_config_pkg::bit_auto_overhead];
        cfg.multiframing_select <= wr_data[device_config_pkg::bit_multiframing];
      end
      // Completion of an attempt wins over a simultaneous host write of 0.
      if (activation_done && !cfg.activation_trigger) begin
        cfg.activation_trigger <= 1'b1;
      end else if (wr_en) begin
        cfg.activation_trigger <= wr_data[device_config_pkg::bit_activation];
      end
    end
  end

  // One attempt per falling transition of the trigger bit.
  logic act_prev_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_prev_q <= 1'b1;
    end else begin
      act_prev_q <= cfg.activation_trigger;
    end
  end
  assign activation_attempt = act_prev_q & ~cfg.activation_trigger;

  assign device_reset_n = cfg.soft_reset_n;

  // Auxiliary clock control.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_clock_oe_n <= 1'b1;
      aux_clock_locked <= 1'b0;
      aux_clock_fast <= 1'b0;
    end else begin
      unique case (cfg.clock_out_rate_select)
        device_config_pkg::rate_10m24_locked: begin
          aux_clock_oe_n <= 1'b0;
          aux_clock_locked <= u_interface_active;
          aux_clock_fast <= 1'b0;
        end
        device_config_pkg::rate_15m36_free: begin
          aux_clock_oe_n <= 1'b0;
          aux_clock_locked <= 1'b0;
          aux_clock_fast <= 1'b1;
        end
        device_config_pkg::rate_unused, device_config_pkg::rate_tristate: begin
          aux_clock_oe_n <= 1'b1;
          aux_clock_locked <= 1'b0;
          aux_clock_fast <= 1'b0;
        end
      endcase
    end
  end

  // Maintenance and overhead channel steering.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      maint_bits_out <= '1;
      eoc_sm_enable <= 1'b0;
      eoc_manual_enable <= 1'b0;
      eoc_addr_accept <= 1'b0;
    end else begin
      if (cfg.auto_maintenance_enable) begin
        maint_bits_out <= maint_auto_bits;
      end else begin
        maint_bits_out <= maintenance_control_register;
      end
      eoc_sm_enable <= cfg.auto_overhead_channel_enable & cfg.soft_reset_n;
      eoc_manual_enable <= ~cfg.auto_overhead_channel_enable & cfg.soft_reset_n;
      eoc_addr_accept <= cfg.auto_overhead_channel_enable & cfg.soft_reset_n &
                         eoc_addr_ok(eoc_rx_addr);
    end
  end

  // Multiframing controls and forced read values.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_ctl <= '{fa_m_force_zero: 1'b1, s_force_one: 1'b1, mf_controller_enable: 1'b0};
      q_channel_register <= device_config_pkg::q_forced_value;
      s_subchannel_registers <= '0;
    end else if (cfg.multiframing_select) begin
      frame_ctl <= '{fa_m_force_zero: 1'b1, s_force_one: 1'b1, mf_controller_enable: 1'b0};
      q_channel_register <= device_config_pkg::q_forced_value;
      s_subchannel_registers <= {subchannels{device_config_pkg::s_forced_value}};
    end else begin
      frame_ctl <= '{fa_m_force_zero: 1'b0, s_force_one: 1'b0, mf_controller_enable: 1'b1};
      q_channel_register <= q_channel_raw;
      s_subchannel_registers <= s_subchannel_raw;
    end
  end

endmodule : device_config_control
`default_nettype wire

// ==== tb/device_config_control_properties.sv ====
// Port checks for the device configuration block.
`timescale 1ns/100ps
`default_nettype none
module device_config_control_properties #(
  parameter int maint_bits = 6,
  parameter int subchannels = 5
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic u_interface_active,
  input wire logic activation_done,
  input wire logic [maint_bits-1:0] maint_auto_bits,
  input wire logic [maint_bits-1:0] maintenance_control_register,
  input wire logic [2:0] eoc_rx_addr,
  input wire device_config_pkg::dev_cfg_t cfg,
  input wire logic device_reset_n,
  input wire logic aux_clock_oe_n,
  input wire logic aux_clock_fast,
  input wire logic aux_clock_locked,
  input wire logic [maint_bits-1:0] maint_bits_out,
  input wire logic eoc_sm_enable,
  input wire logic eoc_manual_enable,
  input wire logic eoc_addr_accept,
  input wire device_config_pkg::frame_ctl_t frame_ctl,
  input wire logic [3:0] q_channel_register,
  input wire logic [subchannels*4-1:0] s_subchannel_registers,
  input wire logic activation_attempt
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence trig_fall;
    $fell(cfg.activation_trigger);
  endsequence
  sequence attempt_finished;
    activation_done && !cfg.activation_trigger && cfg.soft_reset_n;
  endsequence
  rate_fast_a: assert property ($past(arst_n) |->
    aux_clock_fast == ($past(cfg.clock_out_rate_select) == 2'h2)) else $error("fast");
  rate_drive_a: assert property ($past(arst_n) |->
    aux_clock_oe_n == !($past(cfg.clock_out_rate_select) inside {2'h1, 2'h2})) else $error("oe");
  eoc_enable_a: assert property ($past(arst_n) |-> {eoc_sm_enable, eoc_manual_enable} ==
    $past({cfg.auto_overhead_channel_enable, !cfg.auto_overhead_channel_enable}
    & {2{cfg.soft_reset_n}})) else $error("eoc enable");
  eoc_address_a: assert property ($past(arst_n) |-> eoc_addr_accept ==
    ($past(eoc_rx_addr) inside {3'h0, 3'h7} &&
    $past(cfg.auto_overhead_channel_enable && cfg.soft_reset_n))) else $error("addr");
  frame_mode_a: assert property ($past(arst_n) |-> frame_ctl ==
    {{2{$past(cfg.multiframing_select)}}, !$past(cfg.multiframing_select)}) else $error("frame");
  attempt_start_a: assert property (trig_fall |-> ##[0:1] activation_attempt)
    else $error("attempt");
  attempt_pulse_a: assert property (activation_attempt |=> !activation_attempt)
    else $error("pulse");
  soft_reset_a: assert property (!device_reset_n |-> cfg == 7'h7e)
    else $error("reset");
  rate_locked_a: assert property ($past(arst_n) |-> aux_clock_locked ==
    ($past(cfg.clock_out_rate_select) == 2'h1 && $past(u_interface_active))) else $error("locked");
  maint_select_a: assert property ($past(arst_n) |-> maint_bits_out ==
    ($past(cfg.auto_maintenance_enable) ? $past(maint_auto_bits) :
    $past(maintenance_control_register))) else $error("maint");
  forced_read_a: assert property ($past(arst_n) && $past(cfg.multiframing_select) |->
    q_channel_register == 4'hf && s_subchannel_registers == '0) else $error("forced");
  trigger_restore_a: assert property (attempt_finished |=> cfg.activation_trigger)
    else $error("restore");
endmodule : device_config_control_properties
bind device_config_control device_config_control_properties #(.maint_bits(maint_bits),
  .subchannels(subchannels)) device_config_control_properties_inst (.clk, .arst_n,
  .u_interface_active, .activation_done, .maint_auto_bits, .maintenance_control_register,
  .eoc_rx_addr, .cfg, .device_reset_n, .aux_clock_oe_n, .aux_clock_fast, .aux_clock_locked,
  .maint_bits_out, .eoc_sm_enable, .eoc_manual_enable, .eoc_addr_accept, .frame_ctl,
  .q_channel_register, .s_subchannel_registers, .activation_attempt);
`default_nettype wire

// ==== tb/host_port_model.sv ====
// Host serial port master that frames register reads and writes.
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
  input wire logic clk,
  input wire logic sdo,
  output logic sclk = 1'b0,
  output logic cs_n = 1'b1,
  output logic sdi = 1'b0,
  output logic rd_valid = 1'b0,
  output logic [7:0] rd_data = 8'h00
);
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rd, a, d};
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi <= (rd && i < 8) ? ~sdi : f[i];
      repeat (6) @(posedge clk);
      sclk <= 1'b1;
      if (rd && i < 8) rd_data[i] <= sdo;
      repeat (6) @(posedge clk);
      sclk <= 1'b0;
    end
    rd_valid <= rd;
    @(posedge clk);
    rd_valid <= 1'b0;
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : host_port_model
`default_nettype wire

// ==== tb/test_device_config_control.sv ====
// Self-checking bench for the device configuration block.
`timescale 1ns/100ps
`default_nettype none
module test_device_config_control;
  logic clk = 1'b0, arst_n = 1'b0, activation_strap_pin = 1'b1, u_interface_active = 1'b0;
  logic [3:0] q_channel_raw = 4'h0, att_d = 4'h0, q_channel_register;
  logic [5:0] maint_auto_bits = 6'h3f, maintenance_control_register = 6'h3f, maint_bits_out;
  logic [2:0] eoc_rx_addr = 3'h0;
  logic [19:0] s_subchannel_raw = 20'h0, s_subchannel_registers;
  logic host_sclk, host_cs_n, host_sdi, host_sdo, host_sdo_oe_n, device_reset_n, aux_clock_oe_n;
  logic aux_clock_locked, aux_clock_fast, eoc_sm_enable, eoc_manual_enable, eoc_addr_accept;
  logic activation_attempt, rd_valid;
  logic [7:0] rd_data, exp_q[$];
  wire logic activation_done = att_d[3];
  device_config_pkg::dev_cfg_t cfg;
  device_config_pkg::frame_ctl_t frame_ctl;
  int failures = 0, compares = 0, attempts = 0;
  device_config_control device_config_control_inst (.clk, .arst_n, .host_sclk, .host_cs_n,
    .host_sdi, .host_sdo, .host_sdo_oe_n, .activation_strap_pin, .u_interface_active,
    .activation_done, .maint_auto_bits, .maintenance_control_register, .eoc_rx_addr,
    .q_channel_raw, .s_subchannel_raw, .cfg, .device_reset_n, .aux_clock_oe_n, .aux_clock_locked,
    .aux_clock_fast, .maint_bits_out, .eoc_sm_enable, .eoc_manual_enable, .eoc_addr_accept,
    .frame_ctl, .q_channel_register, .s_subchannel_registers, .activation_attempt);
  host_port_model host_port_model_inst (.clk, .sdo(host_sdo), .sclk(host_sclk),
    .cs_n(host_cs_n), .sdi(host_sdi), .rd_valid, .rd_data);
  task automatic compare(input logic [19:0] e, input logic [19:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
    end
  endtask : compare
  task automatic end_of_test();
    if (exp_q.size() != 0) failures++;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] d);
    host_port_model_inst.xfer(1'b0, 7'h00, d);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_port_model_inst.xfer(1'b1, a, 8'h00);
  endtask : rd
  task automatic do_reset(input logic s);
    arst_n <= 1'b0;
    activation_strap_pin <= s;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100us;
    failures++;
    end_of_test();
  end
  always @(posedge rd_valid) begin
    compare(20'(exp_q.pop_front()), 20'(rd_data));
    compare(20'(host_sdo_oe_n), 20'h0);
  end
  always @(posedge clk) att_d <= {att_d[2:0], activation_attempt === 1'b1};
  always @(posedge clk) if (activation_attempt === 1'b1) attempts++;
  initial begin
    logic [7:0] v;
    void'($urandom(5));
    do_reset(1'b1);
    rd(7'h00, 8'hff);
    rd(7'h05, 8'h00);
    for (int r = 0; r < 4; r++) begin
      v = {5'h1f, r[1:0], 1'b1};
      u_interface_active <= r[0];
      wr(v);
      rd(7'h00, v);
      compare(20'({host_sdo_oe_n, aux_clock_oe_n, aux_clock_locked, aux_clock_fast}),
        20'({1'b1, r == 0 || r == 3, r == 1, r == 2}));
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom) | 8'h41;
      v[5] = i[1];
      v[3] = i[0];
      v[4] = i[0] ^ i[1];
      maint_auto_bits <= 6'($urandom);
      maintenance_control_register <= 6'($urandom);
      q_channel_raw <= 4'($urandom);
      s_subchannel_raw <= 20'($urandom);
      wr(v);
      rd(7'h00, v | 8'h80);
      compare(20'(maint_bits_out), 20'(v[3] ? maint_auto_bits : maintenance_control_register));
      compare(20'({frame_ctl, eoc_sm_enable, eoc_manual_enable}),
        20'({v[5], v[5], !v[5], v[4], !v[4]}));
      compare(20'(q_channel_register), v[5] ? 20'hf : 20'(q_channel_raw));
      compare(s_subchannel_registers, v[5] ? 20'h0 : s_subchannel_raw);
      for (int a = 0; a < 8; a++) begin
        eoc_rx_addr <= 3'(a);
        repeat (3) @(posedge clk);
        compare(20'(eoc_addr_accept), 20'(v[4] && (a == 0 || a == 7)));
      end
    end
    for (int k = 1; k < 3; k++) begin
      wr(8'hbf);
      rd(7'h00, 8'hff);
      compare(20'(attempts), 20'(k));
    end
    wr(8'hc1);
    activation_strap_pin <= 1'b0;
    wr(8'h00);
    rd(7'h00, 8'hfe);
    compare(20'({device_reset_n, eoc_sm_enable, eoc_manual_enable}), 20'h0);
    wr(8'h41);
    rd(7'h00, 8'hff);
    compare(20'(attempts), 20'h2);
    do_reset(1'b0);
    rd(7'h00, 8'hff);
    compare(20'(attempts), 20'h3);
    end_of_test();
  end
endmodule : test_device_config_control
`default_nettype wire
